// ===== air_peer.sv
// Remote radio model feeding air bits to the receiver
`timescale 1ns/1ns
module air_peer (
  input  logic          i_ref_clk,
  output pkt_pkg::bit_t o_air
);
  logic [7:0] q[$];
  int         k = 7;
  initial o_air = '0;
  // preamble tail and sync lead the framed bytes
  task automatic send(input logic [7:0] b[$]);
    q = {8'h55, 8'h55, 8'h54, 8'h3D, b};
  endtask
  always @(posedge i_ref_clk) begin
    if (q.size() == 0) begin
      // Idle line toggles so a stale level is never trusted
      o_air <= '{1'b0, ~o_air.level};
    end else begin
      o_air <= '{1'b1, q[0][k]};
      if (k == 0) void'(q.pop_front());
      k = (k == 0) ? 7 : k - 1;
    end
  end
endmodule // air_peer

// ===== crc16_unit.sv
// Byte-wide CRC-16 accumulator with block restart
`timescale 1ns/1ns
module crc16_unit #(
  parameter logic [15:0] POLY = pkt_pkg::CRC_POLY
) (
  input  logic        i_ref_clk,
  input  logic        i_reset_n,
  input  logic        i_clear,
  input  logic        i_update,
  input  logic [7:0]  i_data,
  output logic [15:0] o_crc
);
  logic [15:0] crc_ff;
  logic [15:0] base;

  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      r = (r[15] ^ d[k]) ? ((r << 1) ^ POLY) : (r << 1);
    end
    return r;
  endfunction

  // Clear and a first byte may share a cycle
  assign base  = i_clear ? pkt_pkg::CRC_INIT : crc_ff;
  assign o_crc = crc_ff;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      crc_ff <= pkt_pkg::CRC_INIT;
    end else if (i_update) begin
      crc_ff <= step(base, i_data);
    end else if (i_clear) begin
      crc_ff <= pkt_pkg::CRC_INIT;
    end
  end
endmodule // crc16_unit

// ===== pkt_handler.sv
// Format A packet framer and parser with register port and interrupt
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module pkt_handler (
  input  logic              i_ref_clk,
  input  logic              i_reset_n,
  input  pkt_pkg::reg_req_t i_reg,
  output logic [7:0]        o_reg_rdata,
  input  pkt_pkg::byte_t    i_tx,
  output logic              o_tx_ready,
  output pkt_pkg::byte_t    o_rx,
  output pkt_pkg::bit_t     o_air_tx,
  input  pkt_pkg::bit_t     i_air_rx,
  output logic              o_irq
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_PRE = 5'h02, TX_SYNC = 5'h04, TX_DATA = 5'h08, TX_CRC = 5'h10
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_HUNT = 3'h1, RX_DATA = 3'h2, RX_CRC = 3'h4
  } rx_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_one_ff;
  logic [7:0]  ctrl_two_ff;
  logic [7:0]  status_ff;
  logic [7:0]  mask_ff;
  logic [7:0]  pre_len_ff;
  logic [15:0] sync_ff;
  logic [7:0]  mode_ff;
  logic [7:0]  ev;
  logic [7:0]  clr;
  logic [7:0]  rd_mux;
  logic        fmt_a;
  logic        g_en;
  logic        ext_off;
  logic        dat_lsb;
  logic        len_lsb;

  function automatic logic [7:0] order(input logic [7:0] b, input logic lsb_first);
    return lsb_first ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
  endfunction

  assign fmt_a   = ctrl_one_ff[pkt_pkg::FMT_LSB +: 2] == pkt_pkg::FMT_A;
  assign g_en    = ctrl_one_ff[pkt_pkg::G_EN_BIT];
  assign ext_off = ctrl_one_ff[pkt_pkg::RXEXT_OFF_BIT];
  assign dat_lsb = ctrl_one_ff[pkt_pkg::DAT_ORD_BIT];
  assign len_lsb = ctrl_one_ff[pkt_pkg::LEN_ORD_BIT];

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_one_ff <= pkt_pkg::CTRL_ONE_RST;
      ctrl_two_ff <= pkt_pkg::CTRL_TWO_RST;
      mask_ff     <= pkt_pkg::MASK_RST;
      pre_len_ff  <= pkt_pkg::PRE_LEN_RST;
      sync_ff     <= pkt_pkg::SYNC_RST;
      mode_ff     <= pkt_pkg::MODE_RST;
    end else if (i_reg.wr) begin
      case (i_reg.addr)
        pkt_pkg::ADDR_CTRL_ONE: ctrl_one_ff   <= i_reg.wdata;
        pkt_pkg::ADDR_CTRL_TWO: ctrl_two_ff   <= i_reg.wdata;
        pkt_pkg::ADDR_MASK:     mask_ff       <= i_reg.wdata;
        pkt_pkg::ADDR_PRE_LEN:  pre_len_ff    <= i_reg.wdata;
        pkt_pkg::ADDR_SYNC_HI:  sync_ff[15:8] <= i_reg.wdata;
        pkt_pkg::ADDR_SYNC_LO:  sync_ff[7:0]  <= i_reg.wdata;
        pkt_pkg::ADDR_MODE:     mode_ff       <= i_reg.wdata;
        default: ;
      endcase
    end
  end

  // Write one to clear; an event in the same cycle wins
  assign clr = (i_reg.wr && i_reg.addr == pkt_pkg::ADDR_STATUS) ? i_reg.wdata : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= (status_ff & ~clr) | ev;
    end
  end

  assign o_irq = |(status_ff & mask_ff);

  always_comb begin
    case (i_reg.addr)
      pkt_pkg::ADDR_CTRL_ONE: rd_mux = ctrl_one_ff;
      pkt_pkg::ADDR_CTRL_TWO: rd_mux = ctrl_two_ff;
      pkt_pkg::ADDR_STATUS:   rd_mux = status_ff;
      pkt_pkg::ADDR_MASK:     rd_mux = mask_ff;
      pkt_pkg::ADDR_PRE_LEN:  rd_mux = pre_len_ff;
      pkt_pkg::ADDR_SYNC_HI:  rd_mux = sync_ff[15:8];
      pkt_pkg::ADDR_SYNC_LO:  rd_mux = sync_ff[7:0];
      pkt_pkg::ADDR_MODE:     rd_mux = mode_ff;
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= i_reg.rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  tx_state_t   tx_state_ff;
  logic [10:0] tx_cnt_ff;
  logic [7:0]  tx_shift_ff;
  logic [2:0]  tx_bit_ff;
  logic        tx_have_ff;
  logic        tx_first_ff;
  logic        tx_dio_ff;
  logic        tx_cidx_ff;
  logic [7:0]  tx_left_ff;
  logic [4:0]  tx_blk_ff;
  logic [15:0] tx_crc;
  logic        tx_acc;
  logic        tx_start;
  logic        tx_byte_end;
  logic        tx_blk_end;
  logic        tx_crc_clr;
  logic        tx_done;

  assign o_tx_ready  = (tx_state_ff == TX_DATA) && !tx_have_ff;
  assign tx_acc      = o_tx_ready && i_tx.valid;
  assign tx_start    = (tx_state_ff == TX_IDLE) && i_tx.valid && fmt_a;
  assign tx_byte_end = tx_have_ff && tx_bit_ff == 3'h7;
  assign tx_blk_end  = (tx_blk_ff == 5'h00) || (tx_left_ff == 8'h00);
  assign tx_crc_clr  = tx_start || (tx_state_ff == TX_CRC && tx_byte_end && tx_cidx_ff);
  assign tx_done     = tx_byte_end && tx_left_ff == 8'h00 &&
                       ((tx_state_ff == TX_CRC && tx_cidx_ff) ||
                        (tx_state_ff == TX_DATA && tx_dio_ff));

  crc16_unit u_tx_crc (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clear   (tx_crc_clr),
    .i_update  (tx_acc),
    .i_data    (i_tx.data),
    .o_crc     (tx_crc)
  );

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_state_ff <= TX_IDLE;
      tx_cnt_ff   <= 11'h000;
      tx_shift_ff <= 8'h00;
      tx_bit_ff   <= 3'h0;
      tx_have_ff  <= 1'b0;
      tx_first_ff <= 1'b0;
      tx_dio_ff   <= 1'b0;
      tx_cidx_ff  <= 1'b0;
      tx_left_ff  <= 8'h00;
      tx_blk_ff   <= 5'h00;
    end else begin
      if (tx_have_ff) begin
        tx_bit_ff   <= tx_bit_ff + 3'h1;
        tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
      end
      unique case (tx_state_ff)
        TX_IDLE: if (tx_start) begin
          tx_dio_ff   <= mode_ff[pkt_pkg::DIO_BIT];
          tx_first_ff <= 1'b1;
          tx_have_ff  <= 1'b0;
          tx_bit_ff   <= 3'h0;
          if (pre_len_ff == 8'h00) begin
            tx_state_ff <= TX_SYNC;
            tx_cnt_ff   <= {7'h00, pkt_pkg::SYNC_LAST};
          end else begin
            tx_state_ff <= TX_PRE;
            tx_cnt_ff   <= {pre_len_ff, 3'h0} - 11'h001;
          end
        end
        TX_PRE: if (tx_cnt_ff == 11'h000) begin
          tx_state_ff <= TX_SYNC;
          tx_cnt_ff   <= {7'h00, pkt_pkg::SYNC_LAST};
        end else begin
          tx_cnt_ff <= tx_cnt_ff - 11'h001;
        end
        TX_SYNC: if (tx_cnt_ff == 11'h000) begin
          tx_state_ff <= TX_DATA;
        end else begin
          tx_cnt_ff <= tx_cnt_ff - 11'h001;
        end
        TX_DATA: begin
          if (tx_acc) begin
            tx_have_ff  <= 1'b1;
            tx_bit_ff   <= 3'h0;
            tx_first_ff <= 1'b0;
            tx_shift_ff <= order(i_tx.data, tx_first_ff ? len_lsb : dat_lsb);
            if (tx_first_ff) begin
              tx_left_ff <= i_tx.data;
              tx_blk_ff  <= pkt_pkg::FIRST_BLK - 5'h01;
            end else begin
              tx_left_ff <= tx_left_ff - 8'h01;
              tx_blk_ff  <= g_en ? tx_blk_ff : tx_blk_ff - 5'h01;
            end
          end else if (tx_byte_end) begin
            tx_have_ff <= 1'b0;
            if (tx_blk_end && !tx_first_ff) begin
              if (tx_dio_ff) begin
                tx_blk_ff <= pkt_pkg::NEXT_BLK;
                if (tx_left_ff == 8'h00) begin
                  tx_state_ff <= TX_IDLE;
                end
              end else begin
                tx_state_ff <= TX_CRC;
                tx_cidx_ff  <= 1'b0;
                tx_have_ff  <= 1'b1;
                tx_shift_ff <= order(~tx_crc[15:8], dat_lsb);
              end
            end
          end
        end
        TX_CRC: if (tx_byte_end) begin
          tx_cidx_ff <= ~tx_cidx_ff;
          if (!tx_cidx_ff) begin
            tx_shift_ff <= order(~tx_crc[7:0], dat_lsb);
          end else begin
            tx_have_ff  <= 1'b0;
            tx_blk_ff   <= pkt_pkg::NEXT_BLK;
            tx_state_ff <= (tx_left_ff == 8'h00) ? TX_IDLE : TX_DATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_air_tx <= '0;
    end else begin
      o_air_tx.valid <= (tx_state_ff == TX_PRE) || (tx_state_ff == TX_SYNC) ||
                        (tx_have_ff && (tx_state_ff == TX_DATA || tx_state_ff == TX_CRC));
      unique case (tx_state_ff)
        TX_PRE:  o_air_tx.level <= ~tx_cnt_ff[0];
        TX_SYNC: o_air_tx.level <= sync_ff[tx_cnt_ff[3:0]];
        default: o_air_tx.level <= tx_have_ff & tx_shift_ff[7];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  rx_state_t   rx_state_ff;
  logic [7:0]  rx_sr_ff;
  logic [2:0]  rx_bit_ff;
  logic        rx_first_ff;
  logic        rx_blk1_ff;
  logic        rx_ci_ff;
  logic        rx_cidx_ff;
  logic [7:0]  rx_hi_ff;
  logic [7:0]  rx_left_ff;
  logic [4:0]  rx_blk_ff;
  logic [15:0] rx_crc;
  logic        rx_hit;
  logic        rx_byte;
  logic        rx_dbyte;
  logic        rx_bad;
  logic        rx_done;
  logic        rx_restart;
  logic [7:0]  rx_raw;
  logic [7:0]  rx_val;
  logic [7:0]  nxt_rx_left;
  logic [4:0]  nxt_rx_blk;

  // hunt for preamble tail and sync word
  sync_hunter #(
    .W (24)
  ) u_hunt (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_enable  (rx_state_ff == RX_HUNT && fmt_a),
    .i_bit     (i_air_rx),
    .i_pattern ({pkt_pkg::PREAMBLE_BYTE, sync_ff}),
    .o_hit     (rx_hit)
  );

  assign rx_raw   = {rx_sr_ff[6:0], i_air_rx.level};
  assign rx_byte  = i_air_rx.valid && rx_state_ff != RX_HUNT && rx_bit_ff == 3'h7;
  assign rx_dbyte = rx_byte && rx_state_ff == RX_DATA;
  assign rx_val   = order(rx_raw, (rx_state_ff == RX_DATA && rx_first_ff) ? len_lsb : dat_lsb);
  assign nxt_rx_left = rx_first_ff ? rx_val : rx_left_ff - 8'h01;
  assign nxt_rx_blk  = rx_first_ff ? pkt_pkg::FIRST_BLK - 5'h01 :
                       (g_en ? rx_blk_ff : rx_blk_ff - 5'h01);
  assign rx_bad     = rx_byte && rx_state_ff == RX_CRC && rx_cidx_ff &&
                      ({rx_hi_ff, rx_val} != ~rx_crc);
  assign rx_done    = rx_byte && rx_state_ff == RX_CRC && rx_cidx_ff && rx_left_ff == 8'h00;
  assign rx_restart = rx_byte && rx_state_ff == RX_CRC && rx_cidx_ff;

  crc16_unit u_rx_crc (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clear   (rx_hit || rx_restart),
    .i_update  (rx_dbyte),
    .i_data    (rx_val),
    .o_crc     (rx_crc)
  );

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_state_ff <= RX_HUNT;
      rx_sr_ff    <= 8'h00;
      rx_bit_ff   <= 3'h0;
      rx_first_ff <= 1'b0;
      rx_blk1_ff  <= 1'b0;
      rx_ci_ff    <= 1'b0;
      rx_cidx_ff  <= 1'b0;
      rx_hi_ff    <= 8'h00;
      rx_left_ff  <= 8'h00;
      rx_blk_ff   <= 5'h00;
    end else begin
      if (i_air_rx.valid && rx_state_ff != RX_HUNT) begin
        rx_sr_ff  <= rx_raw;
        rx_bit_ff <= rx_bit_ff + 3'h1;
      end
      unique case (rx_state_ff)
        RX_HUNT: if (rx_hit) begin
          rx_state_ff <= RX_DATA;
          rx_bit_ff   <= 3'h0;
          rx_first_ff <= 1'b1;
          rx_blk1_ff  <= 1'b1;
          rx_ci_ff    <= 1'b0;
        end
        RX_DATA: if (rx_byte) begin
          rx_first_ff <= 1'b0;
          rx_ci_ff    <= 1'b0;
          rx_left_ff  <= nxt_rx_left;
          rx_blk_ff   <= nxt_rx_blk;
          // CRC bytes follow the counted data
          if (!rx_first_ff && (nxt_rx_blk == 5'h00 || nxt_rx_left == 8'h00)) begin
            rx_state_ff <= RX_CRC;
            rx_cidx_ff  <= 1'b0;
          end
        end
        RX_CRC: if (rx_byte) begin
          rx_cidx_ff <= ~rx_cidx_ff;
          rx_hi_ff   <= rx_val;
          if (rx_cidx_ff) begin
            rx_blk_ff   <= pkt_pkg::NEXT_BLK;
            rx_blk1_ff  <= 1'b0;
            rx_ci_ff    <= rx_blk1_ff;
            rx_state_ff <= (rx_left_ff == 8'h00) ? RX_HUNT : RX_DATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx <= '0;
    end else begin
      o_rx.valid <= rx_dbyte;
      if (rx_dbyte) begin
        o_rx.data <= rx_val;
      end
    end
  end

  always_comb begin
    ev = 8'h00;
    ev[pkt_pkg::ST_TX_DONE]   = tx_done;
    ev[pkt_pkg::ST_RX_DONE]   = rx_done;
    ev[pkt_pkg::ST_CRC_ERR]   = rx_bad;
    ev[pkt_pkg::ST_EXT_SHORT] = rx_dbyte && rx_ci_ff && !ext_off &&
                                rx_val == pkt_pkg::CI_EXT_SHORT;
    ev[pkt_pkg::ST_EXT_LONG]  = rx_dbyte && rx_ci_ff && !ext_off &&
                                rx_val == pkt_pkg::CI_EXT_LONG;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  tx_pre_first_a: assert property (
    tx_start && pre_len_ff != 8'h00 |=> tx_state_ff == TX_PRE ##1
    o_air_tx.valid && !o_air_tx.level) else $error("preamble not started");
  tx_sync_order_a: assert property (
    $rose(tx_state_ff == TX_DATA) |-> $past(tx_state_ff) == TX_SYNC ||
    $past(tx_state_ff) == TX_CRC) else $error("data before sync word");
  dio_no_crc_a: assert property (
    tx_state_ff == TX_CRC |-> !tx_dio_ff) else $error("CRC sent in direct I/O");
  crc_err_flag_a: assert property (
    rx_bad |=> status_ff[pkt_pkg::ST_CRC_ERR] ##1 o_irq || !mask_ff[pkt_pkg::ST_CRC_ERR])
    else $error("CRC failure not flagged");
  rx_strip_sync_a: assert property (
    o_rx.valid |-> $past(rx_state_ff) == RX_DATA) else $error("non-data delivered");
  fmt_gate_a: assert property (
    tx_state_ff == TX_IDLE && !fmt_a |=> tx_state_ff == TX_IDLE)
    else $error("frame started outside Format A");
  first_blk_len_a: assert property (
    tx_acc && tx_first_ff |=> tx_left_ff == $past(i_tx.data) &&
    tx_blk_ff == pkt_pkg::FIRST_BLK - 5'h01) else $error("length byte not taken");
  blk_crc_end_a: assert property (
    $rose(tx_state_ff == TX_CRC) |-> tx_blk_ff == 5'h00 || tx_left_ff == 8'h00)
    else $error("CRC inserted mid-block");
  ext_detect_a: assert property (
    rx_dbyte && rx_ci_ff && ext_off |=> !$rose(status_ff[pkt_pkg::ST_EXT_SHORT]))
    else $error("extended layer seen while disabled");
  crc_pair_a: assert property (
    tx_state_ff == TX_CRC && tx_byte_end && !tx_cidx_ff |=> tx_state_ff == TX_CRC [*8])
    else $error("second CRC byte cut short");

  tx_done_c: cover property (tx_done && !tx_dio_ff);
  rx_done_c: cover property (rx_done);
  crc_err_c: cover property (rx_bad);
  ext_long_c: cover property (ev[pkt_pkg::ST_EXT_LONG]);
endmodule // pkt_handler

// ===== pkt_pkg.sv
// Constants and carriers shared by the Format A packet handler
package pkt_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0]  ADDR_CTRL_TWO = 8'h05;
  localparam logic [7:0]  ADDR_STATUS   = 8'h06;
  localparam logic [7:0]  ADDR_MASK     = 8'h07;
  localparam logic [7:0]  ADDR_PRE_LEN  = 8'h08;
  localparam logic [7:0]  ADDR_SYNC_HI  = 8'h09;
  localparam logic [7:0]  ADDR_SYNC_LO  = 8'h0A;
  localparam logic [7:0]  ADDR_MODE     = 8'h0B;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0]  CTRL_TWO_RST  = 8'h00;
  localparam logic [7:0]  MASK_RST      = 8'h00;
  localparam logic [7:0]  PRE_LEN_RST   = 8'h04;
  localparam logic [15:0] SYNC_RST      = 16'h543D;
  localparam logic [7:0]  MODE_RST      = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FMT_LSB       = 0;
  localparam int G_EN_BIT      = 2;
  localparam int RXEXT_OFF_BIT = 3;
  localparam int DAT_ORD_BIT   = 4;
  localparam int LEN_ORD_BIT   = 5;
  localparam int EXT_MODE_LSB  = 6;
  localparam int DIO_BIT       = 0;
  localparam int ST_TX_DONE    = 0;
  localparam int ST_RX_DONE    = 1;
  localparam int ST_CRC_ERR    = 2;
  localparam int ST_EXT_SHORT  = 3;
  localparam int ST_EXT_LONG   = 4;
  // ----------------------------------------------------------------
  // Framing values
  // ----------------------------------------------------------------
  localparam logic [1:0]  FMT_A         = 2'h0;
  localparam logic [7:0]  CI_EXT_SHORT  = 8'h8C;
  localparam logic [7:0]  CI_EXT_LONG   = 8'h8D;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h55;
  localparam logic [4:0]  FIRST_BLK     = 5'h0A;
  localparam logic [4:0]  NEXT_BLK      = 5'h10;
  localparam logic [15:0] CRC_POLY      = 16'h3D65;
  localparam logic [15:0] CRC_INIT      = 16'h0000;
  localparam logic [3:0]  SYNC_LAST     = 4'hF;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_t;
  typedef struct packed {
    logic valid;
    logic level;
  } bit_t;
endpackage

// ===== sync_hunter.sv
// Sliding-window search for preamble tail plus sync word
`timescale 1ns/1ns
module sync_hunter #(
  parameter int W = 24
) (
  input  logic          i_ref_clk,
  input  logic          i_reset_n,
  input  logic          i_enable,
  input  pkt_pkg::bit_t i_bit,
  input  logic [W-1:0]  i_pattern,
  output logic          o_hit
);
  logic [W-1:0] window_ff;
  logic [W-1:0] nxt_window;

  assign nxt_window = {window_ff[W-2:0], i_bit.level};
  // Combinational so the bit after the sync word is not missed
  assign o_hit = i_enable && i_bit.valid && (nxt_window == i_pattern);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      window_ff <= '0;
    end else if (!i_enable) begin
      window_ff <= '0;
    end else if (i_bit.valid) begin
      window_ff <= nxt_window;
    end
  end
endmodule // sync_hunter

// ===== tb_top.sv
// Self-checking bench for the Format A packet handler
`timescale 1ns/1ns
module tb_top;
  logic              i_ref_clk = 1'b0;
  logic              i_reset_n = 1'b0;
  pkt_pkg::reg_req_t i_reg     = '0;
  pkt_pkg::byte_t    i_tx      = '0;
  pkt_pkg::byte_t    o_rx;
  pkt_pkg::bit_t     o_air_tx;
  pkt_pkg::bit_t     i_air_rx;
  logic [7:0]        o_reg_rdata;
  logic              o_tx_ready;
  logic              o_irq;
  logic [7:0]        txq[$];
  logic [7:0]        rxq[$];
  logic              air[$];
  int                error_cnt = 0;
  int                compares  = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  pkt_handler pkt_handler_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_reg(i_reg),
    .o_reg_rdata(o_reg_rdata), .i_tx(i_tx), .o_tx_ready(o_tx_ready), .o_rx(o_rx),
    .o_air_tx(o_air_tx), .i_air_rx(i_air_rx), .o_irq(o_irq));
  air_peer air_peer_i (.i_ref_clk(i_ref_clk), .o_air(i_air_rx));
  always @(posedge i_ref_clk) begin
    if (i_tx.valid === 1'b1 && o_tx_ready === 1'b1) void'(txq.pop_front());
    i_tx <= '{txq.size() != 0, txq.size() != 0 ? txq[0] : 8'h00};
    if (o_rx.valid === 1'b1) rxq.push_back(o_rx.data);
    if (o_air_tx.valid === 1'b1) air.push_back(o_air_tx.level);
  end
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk) i_reg <= '{w, ~w, a, d};
    @(posedge i_ref_clk) i_reg <= '0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_cyc(1'b1, a, d);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    reg_cyc(1'b0, a, 8'h00);
    #1 v = o_reg_rdata;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] b, input logic r);
    for (int k = 0; k < 8; k++) rev[k] = r ? b[7-k] : b[k];
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = pkt_pkg::CRC_INIT;
    foreach (b[i]) begin
      c ^= {b[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? (c << 1) ^ pkt_pkg::CRC_POLY : c << 1;
    end
    return ~c;
  endfunction
  // block of ten, then sixteen, each closed by CRC unless direct_io; one block if g
  function automatic void frame(input logic [7:0] d[$], input logic direct_io, input logic g,
                                output logic [7:0] f[$]);
    logic [7:0]  b[$];
    logic [15:0] c;
    f = {};
    foreach (d[i]) begin
      b.push_back(d[i]);
      if (i == d.size() - 1 || (!g && (i == 9 || (i > 9 && (i - 9) % 16 == 0)))) begin
        c = crc(b);
        f = {f, b};
        if (!direct_io) f = {f, c[15:8], c[7:0]};
        b = {};
      end
    end
  endfunction
  task automatic tx_run(input logic [7:0] c1, input logic direct_io, input int n);
    logic [7:0] d[$], f[$], x[$], v;
    logic       e[$];
    reg_wr(pkt_pkg::ADDR_MODE, {7'h00, direct_io});
    reg_wr(pkt_pkg::ADDR_CTRL_ONE, c1);
    reg_wr(pkt_pkg::ADDR_STATUS, 8'hFF);
    d = {n[7:0]};
    repeat (n) d.push_back(8'($urandom));
    frame(d, direct_io, c1[2], f);
    x = {8'h55, 8'h54, 8'h3D};
    foreach (f[i]) x.push_back(rev(f[i], i == 0 ? c1[5] : c1[4]));
    foreach (x[i]) for (int k = 7; k >= 0; k--) e.push_back(x[i][k]);
    if (c1[1:0] != pkt_pkg::FMT_A) e = {};
    air = {};
    @(negedge i_ref_clk) txq = d;
    for (int t = 0; t < 3000 && air.size() < e.size(); t++) @(posedge i_ref_clk);
    repeat (20) @(posedge i_ref_clk);
    @(negedge i_ref_clk) txq = {};
    check(16'(air.size()), 16'(e.size()));
    foreach (e[i]) check(air[i], e[i]);
    reg_rd(pkt_pkg::ADDR_STATUS, v);
    check(v, {7'h00, e.size() != 0});
    reg_rd(pkt_pkg::ADDR_CTRL_ONE, v);
    check(v, c1);
  endtask
  task automatic rx_run(input logic [7:0] c1, input int n, input logic [7:0] ci, input logic bad);
    logic [7:0] d[$], f[$], v, s;
    reg_wr(pkt_pkg::ADDR_CTRL_ONE, c1);
    reg_wr(pkt_pkg::ADDR_STATUS, 8'hFF);
    d = {n[7:0]};
    repeat (n) d.push_back(8'($urandom));
    if (n >= 10) d[10] = ci;
    frame(d, 1'b0, c1[2], f);
    foreach (f[i]) f[i] = rev(f[i], i == 0 ? c1[5] : c1[4]);
    if (bad) f[f.size() - 1] ^= 8'h01;
    rxq = {};
    @(negedge i_ref_clk) air_peer_i.send(f);
    for (int t = 0; t < 4000 && air_peer_i.q.size() != 0; t++) @(posedge i_ref_clk);
    repeat (20) @(posedge i_ref_clk);
    check(16'(rxq.size()), 16'(d.size()));
    foreach (d[i]) check(rxq[i], d[i]);
    s = {3'h0, ci == 8'h8D && !c1[3], ci == 8'h8C && !c1[3], bad, 2'h2};
    reg_rd(pkt_pkg::ADDR_STATUS, v);
    check(v, s);
    check(o_irq, bad);
    reg_wr(pkt_pkg::ADDR_STATUS, 8'hFF);
    repeat (2) @(posedge i_ref_clk);
    check(o_irq, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  v;
    logic [15:0] rv[8];
    rv = '{16'h0400, 16'h0500, 16'h0804, 16'h0954, 16'h0A3D, 16'h3300, 16'h0700, 16'h0B00};
    void'($urandom(36));
    repeat (16) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    foreach (rv[i]) begin
      reg_rd(rv[i][15:8], v);
      check(v, rv[i][7:0]);
    end
    reg_wr(pkt_pkg::ADDR_PRE_LEN, 8'h01);
    reg_wr(pkt_pkg::ADDR_MASK, 8'h04);
    tx_run(8'h40, 1'b0, 10);
    tx_run(8'hB0, 1'b1, 3);
    tx_run(8'h01, 1'b0, 2);
    tx_run(8'h24, 1'b0, 20);
    rx_run(8'h00, 10, 8'h8C, 1'b0);
    rx_run(8'h00, 12, 8'h8D, 1'b0);
    rx_run(8'h08, 10, 8'h8C, 1'b0);
    rx_run(8'h00, 27, 8'h00, 1'b1);
    rx_run(8'h34, 20, 8'h00, 1'b0);
    report_and_stop();
  end
  // Hang guard, well past the longest frame sequence
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_top
